// file: rtl/ccst_session_timer.v
// control channel session timer: session open/close, start and end timeouts,
// mode selection, come-back timer and forwarding buffer
// assumes frame sync and host activity pins are asynchronous to clk_sys,
// and that frames decoded by the link logic arrive as clk_sys pulses
//
// Contract
// - by default the session opens on the falling frame-sync edge.
// - active frame-sync edge is programmable per device, independently.
// - base mode forwards host packets to the peripheral as i2c.
// - base mode returns peripheral i2c answers toward the host; this block has no such return path, it only forwards host to peripheral.
// - peripheral enable at zero blocks all peripheral traffic.
// - after reset the block is in base mode.
// - interface mode one is i2c base, zero is raw bypass.
// - bypass ends only on come-back expiry, clearing peripheral enable.
// - start prescaler divides pixel clock 16 up to 32768 by code.
// - start counter advances per prescaled tick, expires at limit plus one.
// - host must talk before start expiry, else the session closes.
// - after reset start timeout is 1024 cycles.
// - host activity stops the start timer and starts the end timer.
// - end timer same encoding, reset by activity, expiry closes session.
// - sync then close frame closes the session, base mode only; the code also honours it in raw mode while peripheral enable is zero.
// - come-back counts bit times, zero locks out, else 16 per step.
`include "ccst_defines.vh"

module ccst_session_timer (
  input wire clk_sys,
  input wire resetn,
  input wire frame_sync,
  input wire host_activity,
  input wire sync_frame,
  input wire close_frame,
  input wire uart_bit_tick,
  input wire [1:0] reg_sel,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [7:0] host_data,
  input wire host_data_valid,
  output reg host_data_ready,
  output reg [7:0] periph_data,
  output reg periph_valid,
  input wire periph_ready,
  output reg [1:0] fwd_mode,
  output reg channel_open_flag,
  output reg bypass_active
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [1:0] fs_sync_q;
  reg [1:0] act_sync_q;
  reg fs_prev_q;
  reg act_prev_q;

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      fs_sync_q <= 2'h3;
      act_sync_q <= 2'h0;
      fs_prev_q <= 1'b1;
      act_prev_q <= 1'b0;
    end
    else
    begin
      fs_sync_q <= {fs_sync_q[0], frame_sync};
      act_sync_q <= {act_sync_q[0], host_activity};
      fs_prev_q <= fs_sync_q[1];
      act_prev_q <= act_sync_q[1];
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  reg [7:0] start_timeout_config_q;
  reg [7:0] end_timeout_config_q;
  reg [7:0] link_mode_q;
  reg [2:0] come_back_timeout_q;
  wire pen;
  wire ifsel;
  wire edge_rise;
  wire fs_edge;
  wire activity;

  assign pen = link_mode_q[`CCST_MODE_PEN];
  assign ifsel = link_mode_q[`CCST_MODE_IFSEL];
  assign edge_rise = link_mode_q[`CCST_MODE_EDGE];
  // active edge select, falling by default
  assign fs_edge = edge_rise ? (fs_sync_q[1] && !fs_prev_q)
                             : (!fs_sync_q[1] && fs_prev_q);
  assign activity = act_sync_q[1] && !act_prev_q;

  reg [1:0] state_q;
  reg [14:0] pre_q;
  reg [4:0] cnt_q;
  reg [14:0] pre_lim_q;
  reg [4:0] cnt_lim_q;
  reg [7:0] cmbk_cnt_q;
  wire cmbk_expire;

  // bypass is left only when come-back expires
  assign cmbk_expire = bypass_active && (come_back_timeout_q != `CCST_CMBK_RST)
    && uart_bit_tick
    && (cmbk_cnt_q == {come_back_timeout_q, 4'h0} - 8'h01) && !activity;

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      start_timeout_config_q <= `CCST_START_RST;
      end_timeout_config_q <= `CCST_END_RST;
      link_mode_q <= `CCST_MODE_RST;
      come_back_timeout_q <= `CCST_CMBK_RST;
    end
    else
    begin
      // in bypass the device registers ignore writes
      if (reg_wr && !bypass_active)
      begin
        if (reg_sel == `CCST_SEL_START)
          start_timeout_config_q <= reg_wdata;
        else if (reg_sel == `CCST_SEL_END)
          end_timeout_config_q <= reg_wdata;
        else if (reg_sel == `CCST_SEL_MODE)
          link_mode_q <= reg_wdata;
        else
          come_back_timeout_q <= reg_wdata[2:0];
      end
      if (cmbk_expire)
        link_mode_q[`CCST_MODE_PEN] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // readback
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_sel == `CCST_SEL_START)
      reg_rdata <= start_timeout_config_q;
    else if (reg_sel == `CCST_SEL_END)
      reg_rdata <= end_timeout_config_q;
    else if (reg_sel == `CCST_SEL_MODE)
      reg_rdata <= link_mode_q;
    else
      reg_rdata <= {channel_open_flag, bypass_active, state_q, 1'b0, come_back_timeout_q};
  end

  // ------------------------------------------------------------
  // divide ratio decode: codes below 4 act as 4
  // ------------------------------------------------------------
  function [14:0] div_last;
    input [3:0] code;
    reg [3:0] c;
    begin
      c = (code < `CCST_DIV_MIN_CODE) ? `CCST_DIV_MIN_CODE : code;
      div_last = (15'h0001 << (c - `CCST_DIV_MIN_CODE + `CCST_DIV_MIN_LOG)) - 15'h0001;
    end
  endfunction

  // ------------------------------------------------------------
  // session state machine
  // ------------------------------------------------------------
  wire tick;
  wire expire;
  reg sync_seen_q;

  assign tick = (pre_q == pre_lim_q);
  assign expire = tick && (cnt_q + 5'h01 == cnt_lim_q);

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= `CCST_ST_VIDEO;
      pre_q <= 15'h0000;
      cnt_q <= 5'h00;
      pre_lim_q <= 15'h0000;
      cnt_lim_q <= 5'h00;
      sync_seen_q <= 1'b0;
      channel_open_flag <= 1'b0;
    end
    else
    begin
      case (state_q)
        `CCST_ST_VIDEO:
        begin
          pre_q <= 15'h0000;
          cnt_q <= 5'h00;
          sync_seen_q <= 1'b0;
          if (fs_edge)
          begin
            state_q <= `CCST_ST_START;
            channel_open_flag <= 1'b1;
            // start limits latched at session open
            pre_lim_q <= div_last(start_timeout_config_q[7:4]);
            cnt_lim_q <= {1'b0, start_timeout_config_q[3:0]} + 5'h01;
          end
        end
        `CCST_ST_START:
        begin
          if (activity)
          begin
            state_q <= `CCST_ST_END;
            pre_q <= 15'h0000;
            cnt_q <= 5'h00;
            pre_lim_q <= div_last(end_timeout_config_q[7:4]);
            cnt_lim_q <= {1'b0, end_timeout_config_q[3:0]} + 5'h01;
          end
          else if (expire)
          begin
            state_q <= `CCST_ST_VIDEO;
            channel_open_flag <= 1'b0;
          end
          else
          begin
            pre_q <= tick ? 15'h0000 : pre_q + 15'h0001;
            cnt_q <= tick ? cnt_q + 5'h01 : cnt_q;
          end
        end
        `CCST_ST_END:
        begin
          if (sync_frame)
            sync_seen_q <= 1'b1;
          if (close_frame && sync_seen_q && !bypass_active)
          begin
            state_q <= `CCST_ST_VIDEO;
            channel_open_flag <= 1'b0;
          end
          else if (activity)
          begin
            pre_q <= 15'h0000;
            cnt_q <= 5'h00;
          end
          else if (expire)
          begin
            state_q <= `CCST_ST_VIDEO;
            channel_open_flag <= 1'b0;
          end
          else
          begin
            pre_q <= tick ? 15'h0000 : pre_q + 15'h0001;
            cnt_q <= tick ? cnt_q + 5'h01 : cnt_q;
          end
        end
        default:
        begin
          state_q <= `CCST_ST_VIDEO;
          channel_open_flag <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // come-back timer and mode outputs
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cmbk_cnt_q <= 8'h00;
      bypass_active <= 1'b0;
      fwd_mode <= `CCST_FWD_I2C;
    end
    else
    begin
      if (!bypass_active || activity)
        cmbk_cnt_q <= 8'h00;
      else if (uart_bit_tick)
        cmbk_cnt_q <= cmbk_cnt_q + 8'h01;
      // lockout code keeps bypass indefinitely
      bypass_active <= pen && !ifsel && !cmbk_expire;
      if (!pen || cmbk_expire)
        fwd_mode <= `CCST_FWD_OFF;
      else if (ifsel)
        fwd_mode <= `CCST_FWD_I2C;
      else
        fwd_mode <= `CCST_FWD_RAW;
    end
  end

  // ------------------------------------------------------------
  // forwarding path toward the peripheral bridge
  // ------------------------------------------------------------
  wire fwd_en;
  wire buf_in_ready;
  wire [7:0] buf_data;
  wire buf_valid;
  wire buf_pop;

  assign fwd_en = channel_open_flag && (fwd_mode != `CCST_FWD_OFF);
  assign buf_pop = !periph_valid || periph_ready;

  ccst_buf2 #(
    .W(8)
  ) u_buf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .flush(!fwd_en),
    .in_data(host_data),
    .in_valid(host_data_valid && host_data_ready && fwd_en),
    .in_ready(buf_in_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_pop && fwd_en)
  );

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      periph_data <= 8'h00;
      periph_valid <= 1'b0;
      host_data_ready <= 1'b0;
    end
    else
    begin
      // ready only from an empty buffer: a stale ready never overfills it
      host_data_ready <= buf_in_ready && !buf_valid && fwd_en;
      if (!fwd_en)
        periph_valid <= 1'b0;
      else if (buf_pop)
      begin
        periph_valid <= buf_valid;
        periph_data <= buf_data;
      end
    end
  end

endmodule // ccst_session_timer

// file: pkg/ccst_defines.vh
// control channel session timer: register fields, codes and state encodings
// assumes inclusion by bare name from the rtl files
`ifndef CCST_DEFINES_VH
`define CCST_DEFINES_VH

// ------------------------------------------------------------
// register selects
// ------------------------------------------------------------
`define CCST_SEL_START 2'h0
`define CCST_SEL_END 2'h1
`define CCST_SEL_MODE 2'h2
`define CCST_SEL_CMBK 2'h3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CCST_START_RST 8'ha0
`define CCST_END_RST 8'ha0
`define CCST_MODE_RST 8'h80
`define CCST_CMBK_RST 3'h0

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CCST_MODE_IFSEL 7
`define CCST_MODE_PEN 6
`define CCST_MODE_EDGE 0

// ------------------------------------------------------------
// prescaler code and come-back step
// ------------------------------------------------------------
`define CCST_DIV_MIN_CODE 4'h4
`define CCST_DIV_MIN_LOG 5'h04
`define CCST_CMBK_STEP_LOG 4

// ------------------------------------------------------------
// session states
// ------------------------------------------------------------
`define CCST_ST_VIDEO 2'h0
`define CCST_ST_START 2'h1
`define CCST_ST_END 2'h2

// ------------------------------------------------------------
// forwarding modes
// ------------------------------------------------------------
`define CCST_FWD_OFF 2'h0
`define CCST_FWD_I2C 2'h1
`define CCST_FWD_RAW 2'h2

`endif

// file: rtl/ccst_buf2.v
// two-entry valid/ready buffer for forwarded words
// assumes both sides on clk_sys
`include "ccst_defines.vh"

module ccst_buf2 #(
  parameter W = 8
) (
  input wire clk_sys,
  input wire resetn,
  input wire flush,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  reg [W-1:0] mem_q [0:1];
  reg rd_q;
  reg wr_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end
    else if (flush)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end

endmodule // ccst_buf2

// file: tb/ccst_session_timer_props.sv
// assertions on the session timer ports
// assumes bind onto ccst_session_timer, single clk_sys domain
module ccst_session_timer_props (
  input wire clk_sys,
  input wire resetn,
  input wire frame_sync,
  input wire sync_frame,
  input wire close_frame,
  input wire uart_bit_tick,
  input wire [1:0] reg_sel,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [7:0] periph_data,
  input wire periph_valid,
  input wire periph_ready,
  input wire [1:0] fwd_mode,
  input wire channel_open_flag,
  input wire bypass_active
);
  timeunit 1ns;
  timeprecision 1ps;
  reg sync_seen_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // sync frame seen in this session
  always @(posedge clk_sys or negedge resetn)
    if (!resetn)
      sync_seen_q <= 1'b0;
    else
      sync_seen_q <= channel_open_flag & (sync_seen_q | sync_frame);
  property p_hold;
    periph_valid && !periph_ready |=> periph_valid && $stable(periph_data);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped");
  property p_mode;
    fwd_mode != 2'h3 && bypass_active == (fwd_mode == 2'h2);
  endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
  property p_rdbk;
    (reg_wr && !bypass_active && reg_sel == 2'h0) ##1 (!reg_wr && reg_sel == 2'h0) [*2]
      |-> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rdbk: assert property (p_rdbk) else $error("readback");
  property p_open;
    $rose(channel_open_flag) |-> $past(frame_sync, 1) != $past(frame_sync, 6);
  endproperty
  a_open: assert property (p_open) else $error("open w/o edge");
  property p_minopen;
    $rose(channel_open_flag) |=> channel_open_flag [*8];
  endproperty
  a_minopen: assert property (p_minopen) else $error("short session");
  property p_closeign;
    close_frame && channel_open_flag && (bypass_active || !sync_seen_q) |=> channel_open_flag;
  endproperty
  a_closeign: assert property (p_closeign) else $error("bad close");
  property p_flush;
    $fell(channel_open_flag) |-> ##2 !periph_valid;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_cmbk;
    $fell(bypass_active) |->
      $past(uart_bit_tick, 1) || $past(uart_bit_tick, 2) || $past(uart_bit_tick, 3);
  endproperty
  a_cmbk: assert property (p_cmbk) else $error("bypass left");
endmodule // ccst_session_timer_props

bind ccst_session_timer ccst_session_timer_props u_props (.clk_sys(clk_sys), .resetn(resetn),
  .frame_sync(frame_sync), .sync_frame(sync_frame), .close_frame(close_frame),
  .uart_bit_tick(uart_bit_tick), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .periph_data(periph_data), .periph_valid(periph_valid),
  .periph_ready(periph_ready), .fwd_mode(fwd_mode), .channel_open_flag(channel_open_flag),
  .bypass_active(bypass_active));

// file: tb/ccst_periph_model.sv
// peripheral sink for forwarded words, stalls on request
// assumes clk_sys domain, word taken when valid and ready
module ccst_periph_model (
  input wire clk_sys,
  input wire stall,
  input wire [7:0] periph_data,
  input wire periph_valid,
  output logic periph_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  assign periph_ready = !stall;
  always @(posedge clk_sys)
    if (periph_valid && periph_ready)
      got.push_back(periph_data);
endmodule // ccst_periph_model

// file: tb/tb_ccst_session_timer.sv
// testbench for the control channel session timer
// assumes ccst_session_timer and ccst_periph_model compiled first
module tb_ccst_session_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, resetn = 0, frame_sync = 1, host_activity = 0, stall = 0;
  logic sync_frame = 0, close_frame = 0, uart_bit_tick = 0, reg_wr = 0, host_data_valid = 0;
  logic [1:0] reg_sel = 2'h0;
  logic [7:0] reg_wdata = 8'h00, host_data = 8'h00;
  wire [7:0] reg_rdata, periph_data;
  wire [1:0] fwd_mode;
  wire host_data_ready, periph_valid, periph_ready, channel_open_flag, bypass_active;
  int failures = 0, n_checks = 0, n, k;
  logic [7:0] cfg [4] = '{8'h01, 8'h42, 8'h53, 8'h0f};
  int exps [4] = '{32, 48, 128, 256};
  always #20 clk_sys = ~clk_sys;
  ccst_session_timer u_ccst_session_timer (.clk_sys(clk_sys), .resetn(resetn),
    .frame_sync(frame_sync), .host_activity(host_activity), .sync_frame(sync_frame),
    .close_frame(close_frame), .uart_bit_tick(uart_bit_tick), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_data(host_data),
    .host_data_valid(host_data_valid), .host_data_ready(host_data_ready),
    .periph_data(periph_data), .periph_valid(periph_valid), .periph_ready(periph_ready),
    .fwd_mode(fwd_mode), .channel_open_flag(channel_open_flag), .bypass_active(bypass_active));
  ccst_periph_model u_ccst_periph_model (.clk_sys(clk_sys), .stall(stall),
    .periph_data(periph_data), .periph_valid(periph_valid), .periph_ready(periph_ready));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task stop_test();
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    reg_sel <= s;
    reg_wr <= 1;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task rd(input logic [1:0] s);
    @(posedge clk_sys);
    reg_sel <= s;
    cyc(3);
  endtask
  task fs(input logic v);
    @(posedge clk_sys);
    frame_sync <= v;
  endtask
  task act();
    @(posedge clk_sys);
    host_activity <= 1;
    cyc(4);
    host_activity <= 0;
  endtask
  // one frame pulse: 0 sync, 1 close
  task pz(input int c);
    @(posedge clk_sys);
    if (c == 0)
      sync_frame <= 1;
    else
      close_frame <= 1;
    @(posedge clk_sys);
    sync_frame <= 0;
    close_frame <= 0;
  endtask
  task tick();
    @(posedge clk_sys);
    uart_bit_tick <= 1;
    @(posedge clk_sys);
    uart_bit_tick <= 0;
    cyc(2);
  endtask
  task wflag(input logic v);
    for (n = 0; n < 20 && channel_open_flag !== v; n++)
      @(negedge clk_sys);
    if (channel_open_flag !== v)
    begin
      failures++;
      stop_test();
    end
  endtask
  task opn();
    fs(1);
    cyc(8);
    fs(0);
    wflag(1);
  endtask
  // open time until close, within three cycles of e
  task span(input int e);
    n = 0;
    while (channel_open_flag === 1'b1 && n < 40000)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(n >= e - 3 && n <= e + 3, 1);
    if (n >= 40000)
      stop_test();
  endtask
  task send(input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    host_data <= d;
    host_data_valid <= 1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk_sys);
      if (host_data_ready === 1'b1)
        break;
    end
    host_data_valid <= 0;
    if (i == 50)
    begin
      failures++;
      stop_test();
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    cyc(8);
    resetn <= 1;
    rd(0);
    chk(reg_rdata, 8'ha0);
    rd(1);
    chk(reg_rdata, 8'ha0);
    rd(2);
    chk(reg_rdata, 8'h80);
    chk(fwd_mode, 2'h0);
    chk(bypass_active, 1'b0);
    opn();
    span(1024);
    for (k = 0; k < 4; k++)
    begin
      wr(0, cfg[k]);
      opn();
      span(exps[k]);
    end
    wr(2, 8'h81);
    fs(1);
    wflag(1);
    span(256);
    fs(0);
    cyc(8);
    chk(channel_open_flag, 1'b0);
    wr(1, 8'h41);
    opn();
    cyc(10);
    act();
    cyc(14);
    act();
    span(31);
    opn();
    act();
    cyc(6);
    pz(1);
    cyc(3);
    chk(channel_open_flag, 1'b1);
    pz(0);
    pz(1);
    cyc(3);
    chk(channel_open_flag, 1'b0);
    wr(1, 8'h8f);
    wr(2, 8'hc0);
    opn();
    act();
    chk(fwd_mode, 2'h1);
    stall <= 1;
    send(8'h11);
    send(8'h22);
    cyc(3);
    chk(host_data_ready, 1'b0);
    stall <= 0;
    send(8'h33);
    cyc(6);
    chk(u_ccst_periph_model.got.size(), 3);
    for (k = 0; k < 3; k++)
      chk(u_ccst_periph_model.got[k], 8'h11 * (k + 1));
    chk(periph_valid, 1'b0);
    pz(0);
    pz(1);
    wflag(0);
    wr(2, 8'h80);
    opn();
    act();
    host_data <= 8'h44;
    host_data_valid <= 1;
    cyc(10);
    host_data_valid <= 0;
    chk(u_ccst_periph_model.got.size(), 3);
    pz(0);
    pz(1);
    wflag(0);
    wr(3, 8'h01);
    wr(2, 8'h40);
    cyc(3);
    chk(bypass_active, 1'b1);
    chk(fwd_mode, 2'h2);
    wr(0, 8'h11);
    rd(0);
    chk(reg_rdata, 8'h0f);
    for (k = 0; k < 15; k++)
      tick();
    chk(bypass_active, 1'b1);
    tick();
    cyc(4);
    chk(bypass_active, 1'b0);
    rd(2);
    chk(reg_rdata[6], 1'b0);
    rd(3);
    chk(reg_rdata, 8'h01);
    wr(3, 8'h00);
    wr(2, 8'h40);
    for (k = 0; k < 20; k++)
      tick();
    chk(bypass_active, 1'b1);
    stop_test();
  end
endmodule // tb_ccst_session_timer
